// ---- shared/stw_regs.vh ----
// register map, field positions, reset values and timing counts of the serial channel
`ifndef STW_REGS_VH
`define STW_REGS_VH

`define STW_ADDR_CLKSEL     16'hFF43
`define STW_ADDR_MODE       16'hFF68
`define STW_ADDR_ATCTL      16'hFF69
`define STW_ADDR_INTERVAL   16'hFF6B
`define STW_ADDR_SHIFT      16'hFF6C
`define STW_ADDR_POINTER    16'hFF6D
`define STW_ADDR_BUF_BASE   16'hFAC0

`define STW_RST_CLKSEL      8'h88
`define STW_RST_MODE        8'h00
`define STW_RST_ATCTL       8'h00
`define STW_RST_INTERVAL    8'h00
`define STW_RST_POINTER     5'h00

`define STW_MODE_ENABLE     7
`define STW_MODE_LSB_FIRST  6
`define STW_MODE_AUTO       5
`define STW_MODE_SRC_HI     1
`define STW_MODE_SRC_LO     0

`define STW_AT_RX_ALLOW     7
`define STW_AT_REPEAT       6
`define STW_AT_FAULT_CHK    5
`define STW_AT_ERROR        4
`define STW_AT_ACTIVE       3
`define STW_AT_STROBE       2
`define STW_AT_HS_ENABLE    1
`define STW_AT_HS_POLARITY  0

`define STW_IV_ENABLE       7

`define STW_SEL_MIN         4'h6
`define STW_SEL_MAX         4'hD

`define STW_GAP_UNIT        128
`define STW_GAP_FIXED_MIN   56
`define STW_GAP_FIXED_MAX   72
`define STW_GAP_FIXED       ((`STW_GAP_FIXED_MIN + `STW_GAP_FIXED_MAX) / 2)
`define STW_GAP_MIN_HALVES  4

`endif

// ---- src/stw_buffer_ram.v ----
// small buffer memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none

module stw_buffer_ram #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clock,
    input  wire             wrEn,
    input  wire [AW-1:0]    wrAddr,
    input  wire [WIDTH-1:0] wrData,
    input  wire [AW-1:0]    rdAddr,
    output reg  [WIDTH-1:0] rdData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // stw_buffer_ram

`default_nettype wire

// ---- src/stw_serial_ctrl.v ----
// three-wire serial channel with automatic block transfer and its control registers
`timescale 1ns/1ps
`default_nettype none
`include "stw_regs.vh"

module stw_serial_ctrl #(
    parameter BUF_DEPTH = 32,
    parameter BUF_AW    = 5
) (
    input  wire        clock,
    input  wire        rst,
    input  wire [15:0] cpuAddr,
    input  wire        cpuWrite,
    input  wire        cpuRead,
    input  wire [7:0]  cpuWdata,
    output reg  [7:0]  cpuRdata,
    output reg         cpuRvalid,
    input  wire        timer2Tick,
    input  wire        sckIn,
    output reg         sckOut,
    output reg         sckOeN,
    input  wire        serialDataIn,
    output reg         serialDataOut,
    output reg         sdoOeN,
    output reg         strobePin,
    input  wire        busyIn,
    output reg         channelIrq,
    output reg         portMode
);
    localparam [4:0] ST_IDLE  = 5'b00001;
    localparam [4:0] ST_LOAD  = 5'b00010;
    localparam [4:0] ST_BUSYW = 5'b00100;
    localparam [4:0] ST_SHIFT = 5'b01000;
    localparam [4:0] ST_GAP   = 5'b10000;
    localparam [15:0] GAP_FIXED = `STW_GAP_FIXED;
    localparam [15:0] GAP_UNIT  = `STW_GAP_UNIT;

    reg [7:0]        clkSel;
    reg [7:0]        modeReg;
    reg [7:0]        atCtl;
    reg [7:0]        interval;
    reg [7:0]        shiftReg;
    reg [BUF_AW-1:0] pointer;
    reg [BUF_AW-1:0] startPtr;
    reg [4:0]        state;
    reg [3:0]        bitCnt;
    reg [7:0]        divCnt;
    reg              sckPrev;
    reg [15:0]       gapCnt;
    reg [2:0]        gapHalves;
    reg              autoRun;
    reg [7:0]        regRd;
    reg              rdBuf;
    reg              rdPend;
    reg              activeFlag;
    reg              errorFlag;

    wire       enable    = modeReg[`STW_MODE_ENABLE];
    wire       lsbFirst  = modeReg[`STW_MODE_LSB_FIRST];
    wire       autoMode  = modeReg[`STW_MODE_AUTO];
    wire       srcHi     = modeReg[`STW_MODE_SRC_HI];
    wire       srcLo     = modeReg[`STW_MODE_SRC_LO];
    wire       hsEnable  = atCtl[`STW_AT_HS_ENABLE];
    wire       hsPol     = atCtl[`STW_AT_HS_POLARITY];
    wire       hitShift  = cpuWrite && (cpuAddr == `STW_ADDR_SHIFT);
    wire       startReq  = hitShift && enable && state[0];
    wire [3:0] rateSel   = clkSel[7:4];
    wire       rateOk    = (rateSel >= `STW_SEL_MIN) && (rateSel <= `STW_SEL_MAX);
    wire [3:0] rateShift = rateSel - `STW_SEL_MIN;
    wire [7:0] divMask   = (8'h01 << rateShift[2:0]) - 8'h01;
    wire       intTick   = rateOk && ((divCnt & divMask) == divMask);
    wire       halfTick  = srcLo ? intTick : timer2Tick;
    wire       running   = state[3];
    wire       fallEv    = srcHi ? (running && halfTick && sckOut)
                                 : (running && sckPrev && !sckIn);
    wire       riseEv    = srcHi ? (running && halfTick && !sckOut)
                                 : (running && !sckPrev && sckIn);
    wire       busyAct   = hsEnable && (hsPol ? !busyIn : busyIn);
    wire [7:0] captured  = lsbFirst ? {serialDataIn, shiftReg[7:1]}
                                    : {shiftReg[6:0], serialDataIn};
    wire       lastBit   = riseEv && (bitCnt == 4'h7);
    wire       inBuf     = (cpuAddr >= `STW_ADDR_BUF_BASE)
                        && (cpuAddr < (`STW_ADDR_BUF_BASE + BUF_DEPTH));
    wire [15:0] bufOff   = cpuAddr - `STW_ADDR_BUF_BASE;
    wire [15:0] gapLoad  = (({11'h000, interval[4:0]} + 16'h0001) * GAP_UNIT)
                         + GAP_FIXED;

    wire [7:0]        ramQ;
    reg               ramWe;
    reg [BUF_AW-1:0]  ramWa;
    reg [7:0]         ramWd;
    wire [BUF_AW-1:0] ramRa = autoRun ? pointer : bufOff[BUF_AW-1:0];

    always @* begin
        ramWe = 1'b0;
        ramWa = bufOff[BUF_AW-1:0];
        ramWd = cpuWdata;
        if (autoRun && lastBit && atCtl[`STW_AT_RX_ALLOW]) begin
            ramWe = 1'b1;
            ramWa = pointer;
            ramWd = captured;
        end else if (cpuWrite && inBuf && !autoRun) begin
            ramWe = 1'b1;
        end
    end

    stw_buffer_ram #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH),
        .AW    (BUF_AW)
    ) u_buf (
        .clock  (clock),
        .wrEn   (ramWe),
        .wrAddr (ramWa),
        .wrData (ramWd),
        .rdAddr (ramRa),
        .rdData (ramQ)
    );

    // control registers; flags in the control register are not software writable
    always @(posedge clock) begin
        if (rst) begin
            clkSel   <= `STW_RST_CLKSEL;
            modeReg  <= `STW_RST_MODE;
            atCtl    <= `STW_RST_ATCTL;
            interval <= `STW_RST_INTERVAL;
        end else if (cpuWrite) begin
            case (cpuAddr)
                `STW_ADDR_CLKSEL:   clkSel <= cpuWdata;
                `STW_ADDR_MODE:     modeReg <= {cpuWdata[7:5], 3'b000, cpuWdata[1:0]};
                `STW_ADDR_ATCTL:    atCtl <= {cpuWdata[7:5], 2'b00, cpuWdata[2:0]};
                `STW_ADDR_INTERVAL: interval <= {cpuWdata[7], 2'b00, cpuWdata[4:0]};
                default: ;
            endcase
        end
    end

    // transfer engine; the status flags live only here; software clears active only by disabling the channel or clearing the auto bit, error only by an auto start
    always @(posedge clock) begin
        if (rst) begin
            state         <= ST_IDLE;
            bitCnt        <= 4'h0;
            pointer       <= `STW_RST_POINTER;
            startPtr      <= `STW_RST_POINTER;
            sckOut        <= 1'b1;
            serialDataOut <= 1'b0;
            strobePin     <= 1'b0;
            channelIrq    <= 1'b0;
            autoRun       <= 1'b0;
            gapCnt        <= 16'h0000;
            gapHalves     <= 3'h0;
            activeFlag    <= 1'b0;
            errorFlag     <= 1'b0;
        end else begin
            channelIrq <= 1'b0;
            if (cpuWrite && (cpuAddr == `STW_ADDR_POINTER) && state[0]) begin
                pointer <= cpuWdata[BUF_AW-1:0];
            end
            if (hitShift && state[0]) begin
                shiftReg <= cpuWdata;
            end
            if (!enable) begin
                state     <= ST_IDLE;
                bitCnt    <= 4'h0;
                sckOut    <= 1'b1;
                strobePin <= 1'b0;
                autoRun   <= 1'b0;
                activeFlag <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (startReq) begin
                            bitCnt        <= 4'h0;
                            serialDataOut <= 1'b0;
                            if (autoMode) begin
                                autoRun  <= 1'b1;
                                startPtr <= pointer;
                                activeFlag <= 1'b1;
                                errorFlag  <= 1'b0;
                                state <= ST_LOAD;
                            end else begin
                                state <= ST_SHIFT;
                            end
                        end
                    end
                    ST_LOAD: begin
                        state <= ST_BUSYW;
                    end
                    ST_BUSYW: begin
                        shiftReg <= ramQ;
                        if (!busyAct) begin
                            state <= ST_SHIFT;
                        end
                    end
                    ST_SHIFT: begin
                        if (srcHi && halfTick) begin
                            sckOut <= !sckOut;
                        end
                        if (fallEv) begin
                            serialDataOut <= lsbFirst ? shiftReg[0] : shiftReg[7];
                        end
                        if (riseEv) begin
                            shiftReg <= captured;
                            bitCnt   <= bitCnt + 4'h1;
                        end
                        if (lastBit) begin
                            bitCnt <= 4'h0;
                            if (!autoRun) begin
                                channelIrq <= 1'b1;
                                state <= ST_IDLE;
                            end else begin
                                strobePin <= atCtl[`STW_AT_STROBE];
                                gapCnt    <= interval[`STW_IV_ENABLE] ? gapLoad : 16'h0000;
                                gapHalves <= 3'h0;
                                state     <= ST_GAP;
                            end
                        end
                    end
                    ST_GAP: begin
                        if (gapCnt != 16'h0000) begin
                            gapCnt <= gapCnt - 16'h0001;
                        end
                        if (halfTick && (gapHalves != `STW_GAP_MIN_HALVES)) begin
                            gapHalves <= gapHalves + 3'h1;
                        end
                        if (halfTick && strobePin) begin
                            strobePin <= 1'b0;
                            // a partner that has not raised busy by the end of the strobe is faulty
                            if (atCtl[`STW_AT_FAULT_CHK] && hsEnable && !busyAct) begin
                                errorFlag  <= 1'b1;
                                activeFlag <= 1'b0;
                                autoRun    <= 1'b0;
                                channelIrq <= 1'b1;
                                state      <= ST_IDLE;
                            end
                        end else if (!strobePin && (gapCnt == 16'h0000)
                                     && (gapHalves == `STW_GAP_MIN_HALVES)) begin
                            if (!autoMode) begin
                                autoRun <= 1'b0;
                                activeFlag <= 1'b0;
                                state   <= ST_IDLE;
                            end else if (pointer != {BUF_AW{1'b0}}) begin
                                pointer <= pointer - 1'b1;
                                state   <= ST_LOAD;
                            end else if (atCtl[`STW_AT_REPEAT]) begin
                                pointer <= startPtr;
                                state   <= ST_LOAD;
                            end else begin
                                autoRun    <= 1'b0;
                                channelIrq <= 1'b1;
                                activeFlag <= 1'b0;
                                state      <= ST_IDLE;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // divider and pin sampling; the external clock edge is seen in the cycle the pin changes
    always @(posedge clock) begin
        if (rst) begin
            divCnt   <= 8'h00;
            sckPrev  <= 1'b1;
            sckOeN   <= 1'b1;
            sdoOeN   <= 1'b1;
            portMode <= 1'b1;
        end else begin
            divCnt   <= divCnt + 8'h01;
            sckPrev  <= sckIn;
            sckOeN   <= !(enable && srcHi);
            sdoOeN   <= !enable;
            portMode <= !enable;
        end
    end

    // two-cycle read: register stage then a buffer/register select stage
    always @(posedge clock) begin
        if (rst) begin
            regRd     <= 8'h00;
            rdBuf     <= 1'b0;
            rdPend    <= 1'b0;
            cpuRdata  <= 8'h00;
            cpuRvalid <= 1'b0;
        end else begin
            rdPend <= cpuRead;
            rdBuf  <= inBuf;
            case (cpuAddr)
                `STW_ADDR_CLKSEL:   regRd <= clkSel;
                `STW_ADDR_MODE:     regRd <= modeReg;
                `STW_ADDR_ATCTL:    regRd <= {atCtl[7:5], errorFlag, activeFlag, atCtl[2:0]};
                `STW_ADDR_INTERVAL: regRd <= interval;
                `STW_ADDR_SHIFT:    regRd <= shiftReg;
                `STW_ADDR_POINTER:  regRd <= {{(8-BUF_AW){1'b0}}, pointer};
                default:            regRd <= 8'h00;
            endcase
            cpuRvalid <= rdPend;
            if (rdPend) begin
                cpuRdata <= rdBuf ? ramQ : regRd;
            end
        end
    end
endmodule // stw_serial_ctrl

`default_nettype wire

// ---- verif/stw_peer_model.sv ----
// behavioural peripheral at the far end of the serial link
`timescale 1ns/1ps
`default_nettype none
module stw_peer_model (
    input  wire logic       sckOut,
    input  wire logic       serialDataOut,
    input  wire logic       load,
    input  wire logic [7:0] txByte,
    output var  logic       serialDataIn,
    output var  logic [7:0] rxByte
);
    logic [2:0] idx;
    initial serialDataIn = 1'b0;
    // sender holds data across the rising edge, so sample there
    always @(posedge sckOut) rxByte <= {rxByte[6:0], serialDataOut};
    // load restarts the frame after an aborted transfer
    always @(negedge sckOut or posedge load) begin
        if (load) begin
            idx <= 3'h0;
        end else begin
            serialDataIn <= txByte[3'h7 - idx];
            idx          <= idx + 3'h1;
        end
    end
endmodule // stw_peer_model
`default_nettype wire

// ---- verif/stw_serial_ctrl_bench.sv ----
// self-checking bench for the serial channel control block
`timescale 1ns/1ps
`default_nettype none
`include "stw_regs.vh"
`define CK(a, e) begin totalChecks++; if ((a) !== (e)) begin nFail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module stw_serial_ctrl_bench;
    logic        clock, rst, cpuWrite, cpuRead, busyIn, load, sckIn, timer2Tick;
    logic [15:0] cpuAddr;
    logic [7:0]  cpuWdata, cpuRdata, txByte, rxByte, q;
    logic        cpuRvalid, sckOut, sckOeN, serialDataIn, serialDataOut, sdoOeN;
    logic        strobePin, channelIrq, portMode;
    int          nFail, totalChecks, lowCnt, falls, irqs, stbs;
    int          cyc = 0;
    // the peer follows whichever side drives the clock pin
    wire         linkClk = sckOeN ? sckIn : sckOut;
    stw_serial_ctrl stw_serial_ctrl_i (.clock(clock), .rst(rst), .cpuAddr(cpuAddr),
        .cpuWrite(cpuWrite), .cpuRead(cpuRead), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
        .cpuRvalid(cpuRvalid), .timer2Tick(timer2Tick), .sckIn(sckIn), .sckOut(sckOut),
        .sckOeN(sckOeN), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .sdoOeN(sdoOeN), .strobePin(strobePin), .busyIn(busyIn), .channelIrq(channelIrq),
        .portMode(portMode));
    stw_peer_model stw_peer_model_i (.sckOut(linkClk), .serialDataOut(serialDataOut),
        .load(load), .txByte(txByte), .serialDataIn(serialDataIn), .rxByte(rxByte));
    task automatic reportAndStop();
        if (nFail == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        cpuAddr  <= a;
        cpuWdata <= d;
        cpuWrite <= 1'b1;
        @(posedge clock);
        cpuWrite <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        cpuAddr <= a;
        cpuRead <= 1'b1;
        @(posedge clock);
        cpuRead <= 1'b0;
        repeat (2) @(posedge clock);
        #1 q = cpuRdata;
        `CK(q, e)
    endtask
    task automatic watch(input int n, input bit untilIrq);
        logic pS, pB;
        lowCnt = 0;
        falls = 0;
        irqs = 0;
        stbs = 0;
        pS = sckOut;
        pB = strobePin;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1;
            if (sckOut === 1'b0) lowCnt++;
            if (pS === 1'b1 && sckOut === 1'b0) falls++;
            if (pB === 1'b0 && strobePin === 1'b1) stbs++;
            if (channelIrq === 1'b1) irqs++;
            pS = sckOut;
            pB = strobePin;
            if (untilIrq && channelIrq === 1'b1) break;
        end
    endtask
    task automatic xfer(input logic [3:0] c, input logic [7:0] m, d, t, ed, et);
        wr(`STW_ADDR_CLKSEL, {c, 4'h8});
        wr(`STW_ADDR_MODE, m);
        @(posedge clock);
        txByte <= t;
        load   <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        wr(`STW_ADDR_SHIFT, d);
        watch(3000, 1);
        `CK(irqs, 1)
        `CK(lowCnt, 8 << (c - 6))
        `CK(rxByte, ed)
        rd(`STW_ADDR_SHIFT, et);
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        timer2Tick <= (cyc % 4 == 3);
        if (cyc == 40000) begin
            nFail++;
            reportAndStop();
        end
    end
    initial begin
        cpuAddr = 16'h0000;
        cpuWdata = 8'h00;
        cpuWrite = 1'b0;
        cpuRead = 1'b0;
        rst = 1'b1;
        busyIn = 1'b0;
        load = 1'b0;
        sckIn = 1'b1;
        txByte = 8'h00;
        nFail = 0;
        totalChecks = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(`STW_ADDR_CLKSEL, `STW_RST_CLKSEL);
        rd(`STW_ADDR_MODE, `STW_RST_MODE);
        rd(`STW_ADDR_ATCTL, `STW_RST_ATCTL);
        rd(`STW_ADDR_INTERVAL, `STW_RST_INTERVAL);
        rd(`STW_ADDR_POINTER, 8'h00);
        rd(16'hFF70, 8'h00);
        wr(`STW_ADDR_MODE, 8'h1C);
        rd(`STW_ADDR_MODE, 8'h00);
        wr(`STW_ADDR_MODE, 8'h03);
        wr(`STW_ADDR_ATCTL, 8'hFF);
        rd(`STW_ADDR_ATCTL, 8'hE7);
        wr(`STW_ADDR_ATCTL, 8'h00);
        wr(`STW_ADDR_INTERVAL, 8'hFF);
        rd(`STW_ADDR_INTERVAL, 8'h9F);
        wr(`STW_ADDR_INTERVAL, 8'h00);
        wr(`STW_ADDR_CLKSEL, 8'h77);
        rd(`STW_ADDR_CLKSEL, 8'h77);
        wr(`STW_ADDR_POINTER, 8'h1F);
        rd(`STW_ADDR_POINTER, 8'h1F);
        wr(`STW_ADDR_SHIFT, 8'h55);
        wr(`STW_ADDR_MODE, 8'h83);
        watch(300, 0);
        `CK(falls, 0)
        `CK(irqs, 0)
        // divide-by-two is not allowed at this main clock rate
        for (int c = 7; c <= 13; c++) begin
            xfer(c[3:0], 8'h83, 8'hA5, 8'h3C, 8'hA5, 8'h3C);
        end
        xfer(4'h7, 8'hC3, 8'h1E, 8'hC1, 8'h78, 8'h83);
        wr(`STW_ADDR_CLKSEL, 8'hD8);
        wr(`STW_ADDR_MODE, 8'h83);
        wr(`STW_ADDR_SHIFT, 8'hF0);
        watch(300, 0);
        wr(`STW_ADDR_MODE, 8'h03);
        watch(600, 0);
        `CK(portMode, 1'b1)
        `CK(falls, 0)
        `CK(irqs, 0)
        xfer(4'h8, 8'h83, 8'h69, 8'h96, 8'h69, 8'h96);
        for (int p = 0; p < 2; p++) begin
            wr(`STW_ADDR_BUF_BASE, 8'h11);
            wr(`STW_ADDR_BUF_BASE + 16'h0001, 8'h22);
            wr(`STW_ADDR_POINTER, 8'h01);
            wr(`STW_ADDR_CLKSEL, 8'h78);
            wr(`STW_ADDR_ATCTL, {7'h03, p[0]});
            busyIn <= ~p[0];
            wr(`STW_ADDR_MODE, 8'hA3);
            wr(`STW_ADDR_SHIFT, 8'h00);
            rd(`STW_ADDR_ATCTL, {7'h07, p[0]});
            watch(200, 0);
            `CK(falls, 0)
            @(posedge clock);
            busyIn <= p[0];
            // the block sends pointer 1 then 0, a strobe after each byte and one interrupt at the end
            watch(1500, 0);
            `CK(irqs, 1)
            `CK(stbs, 2)
            `CK(rxByte, 8'h11)
            rd(`STW_ADDR_ATCTL, {7'h03, p[0]});
        end
        // busy never answers the strobe, so the error check stops the block after one byte
        wr(`STW_ADDR_POINTER, 8'h01);
        wr(`STW_ADDR_ATCTL, 8'hA6);
        busyIn <= 1'b0;
        xfer(4'h7, 8'hA3, 8'h00, 8'h5A, 8'h22, 8'h5A);
        `CK(stbs, 1)
        rd(`STW_ADDR_ATCTL, 8'hB6);
        rd(`STW_ADDR_BUF_BASE + 16'h0001, 8'h5A);
        rd(`STW_ADDR_POINTER, 8'h01);
        // repeat mode with the shortest enabled interval: only a handful of bytes fit in the window
        wr(`STW_ADDR_ATCTL, 8'h40);
        wr(`STW_ADDR_INTERVAL, 8'h80);
        wr(`STW_ADDR_POINTER, 8'h00);
        wr(`STW_ADDR_SHIFT, 8'h00);
        watch(1000, 0);
        `CK(falls >= 24 && falls <= 48, 1'b1)
        `CK(irqs, 0)
        wr(`STW_ADDR_MODE, 8'h03);
        rd(`STW_ADDR_ATCTL, 8'h40);
        wr(`STW_ADDR_ATCTL, 8'h00);
        wr(`STW_ADDR_MODE, 8'h80);
        @(posedge clock);
        txByte <= 8'h6B;
        load   <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        wr(`STW_ADDR_SHIFT, 8'hD2);
        fork
            watch(60, 0);
            repeat (8) begin
                repeat (3) @(posedge clock);
                sckIn <= 1'b0;
                repeat (3) @(posedge clock);
                sckIn <= 1'b1;
            end
        join
        `CK(irqs, 1)
        `CK(sckOeN, 1'b1)
        `CK(rxByte, 8'hD2)
        rd(`STW_ADDR_SHIFT, 8'h6B);
        xfer(4'h8, 8'h82, 8'h3C, 8'hA5, 8'h3C, 8'hA5);
        reportAndStop();
    end
endmodule // stw_serial_ctrl_bench
`default_nettype wire

// ---- verif/stw_serial_monitor.sv ----
// port checker for the serial channel control block
`timescale 1ns/1ps
`default_nettype none
module stw_serial_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic cpuRead,
    input wire logic cpuRvalid,
    input wire logic sckOut,
    input wire logic sckOeN,
    input wire logic sdoOeN,
    input wire logic serialDataOut,
    input wire logic strobePin,
    input wire logic channelIrq,
    input wire logic portMode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_RESET_IDLE: assert property ($fell(rst) |-> sckOut && sckOeN && portMode && !channelIrq)
        else $error("outputs not idle after reset");
    AST_RD_LAT: assert property (cpuRead |-> ##2 cpuRvalid)
        else $error("read answer not two cycles after request");
    AST_RD_SRC: assert property (cpuRvalid |-> $past(cpuRead, 2))
        else $error("read answer without request");
    AST_IRQ_PULSE: assert property (channelIrq |=> !channelIrq)
        else $error("interrupt flag longer than one cycle");
    AST_PORT_PINS: assert property (portMode |-> sckOeN && sdoOeN)
        else $error("pins driven while channel disabled");
    AST_STOP_SCK: assert property (portMode && $past(portMode) |-> $stable(sckOut))
        else $error("serial clock moves while disabled");
    AST_DATA_HOLD: assert property ($rose(sckOut) |-> $stable(serialDataOut))
        else $error("data changed at capture edge");
    AST_STB_IDLE: assert property (strobePin |-> sckOut)
        else $error("strobe during a clock low phase");
    AST_EN_SCK: assert property ($fell(sckOut) |-> !portMode)
        else $error("serial clock falls while disabled");
    cover property ($rose(strobePin));
    cover property (channelIrq);
    cover property ($fell(portMode));
endmodule // stw_serial_monitor

bind stw_serial_ctrl stw_serial_monitor stw_serial_monitor_i (.clock(clock), .rst(rst),
    .cpuRead(cpuRead), .cpuRvalid(cpuRvalid), .sckOut(sckOut), .sckOeN(sckOeN),
    .sdoOeN(sdoOeN), .serialDataOut(serialDataOut), .strobePin(strobePin),
    .channelIrq(channelIrq), .portMode(portMode));
`default_nettype wire
